// file: hdl/bias_seq_pkg.sv
// Purpose: shared constants and types for the dual rail bias sequencer
// Assumes: 200 MHz core clock
// Notes:   register map is a plain strobe port, one byte per register
package bias_seq_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [1:0] POS_CODE_OFS   = 2'h0;
	localparam logic [1:0] NEG_CODE_OFS   = 2'h1;
	localparam logic [1:0] STATUS_OFS     = 2'h2;
	localparam logic [1:0] CONTROL_OFS    = 2'h3;
	localparam logic [4:0] CODE_RESET     = 5'h0A;
	localparam int         DIS_NEG_BIT    = 0;
	localparam int         DIS_POS_BIT    = 1;
	localparam int         OFFSET_BIT     = 6;
	localparam int         REG_EN_NEG_BIT = 2;
	localparam int         REG_EN_POS_BIT = 3;
	localparam int         SERIAL_GATE_BIT = 4;
	localparam logic [7:0] CONTROL_RESET  = 8'h03;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 200;
	localparam int PUMP_HALF_NS   = 555;
	localparam int PUMP_HALF_CYC  = (PUMP_HALF_NS * CLK_MHZ) / 1000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RAIL_OFF   = 2'b00,
		RAIL_START = 2'b01,
		RAIL_ON    = 2'b11,
		RAIL_DRAIN = 2'b10
	} rail_state_e;

	typedef struct packed {
		logic pos_en;
		logic neg_en;
		logic lockout_ok;
		logic over_temp;
		logic boost_ready;
	} status_in_s;

endpackage

// file: hdl/dual_rail_bias_sequencer.sv
// Purpose: sequencing of boost, linear regulator and charge pump
// Assumes: all status inputs arrive as levels; analog loops are outside
// Notes:   soft-start ramps are analog; this block only asserts start
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// (R1) all converters off until supply is above lockout; drop all below it.
// (R2) supply above lockout alone never starts a rail; its enable must hold.
// (R3) discharge selected for both rails after reset; software can change it.
// (R4) both enables low, or last one dropping, is a power-down with discharge.
// (R5) one rail off while other stays on: no discharge on either rail.
// (R6) boost runs when any pin or register enable is set and supply is good.
// (R7) enable already high at lockout release starts boost at once.
// (R8) boost stops on lockout or once both rails are disabled.
// (R9) positive regulator starts on enable, supply good and boost ready.
// (R10) positive regulator stops on enable low or lockout.
// (R11) positive rail uses a 5-bit code, 4.0 V plus 100 mV a step.
// (R12) charge pump starts on enable, supply good and boost ready.
// (R13) charge pump stops on enable low or lockout.
// (R14) negative rail uses a 5-bit code, -4.0 V minus 100 mV a step.
// (R15) pump alternates charge phase and inverted phase on four switches.
// (R16) over temperature shuts down at once; resumes when flag clears.
// (R17) headroom offset selectable between 200 mV and 300 mV.
// (R18) enable pins alone switch both rails without serial setup.
// (R19) base variant keeps the register port open with both enables low.
// (R20) alternate variant ignores register port while both enables low.
// (R21) both voltage code registers reset to the same default code.
// (R22) software writes zero into reserved bits.
// (R23) all status inputs pass two-stage synchronisers before use.
// (R24) discharge held only in the off state; released before restart.
module dual_rail_bias_sequencer
	import bias_seq_pkg::*;
#(
	parameter bit GATED_SERIAL = 1'b0 // 1 selects the alternate variant
) (
	input  wire logic       clock_i,       // 200 MHz core clock
	input  wire logic       rst_b_i,       // synchronous reset, active low
	input  wire logic       clk_en_i,      // freezes all state when low
	input  wire logic       pos_rail_enable_pin_i, // positive enable pin
	input  wire logic       neg_rail_enable_pin_i, // negative enable pin
	input  wire logic       supply_lockout_ok_i,   // high: supply above
	input  wire logic       over_temp_i,   // high: junction too hot
	input  wire logic       boost_ready_i, // boost reached target
	input  wire logic [1:0] addr_i,        // register address
	input  wire logic [7:0] wdata_i,       // write data
	input  wire logic       wr_i,          // write strobe
	input  wire logic       rd_i,          // read strobe
	output logic      [7:0] rdata_o,       // read data, one cycle later
	output logic            boost_run_o,   // boost stage enable
	output logic            linear_regulator_run_o, // positive stage on
	output logic            pump_run_o,    // charge pump enable
	output logic            pos_discharge_o, // positive rail discharge
	output logic            neg_discharge_o, // negative rail discharge
	output logic      [4:0] pos_voltage_code_o, // positive rail code
	output logic      [4:0] neg_voltage_code_o, // negative rail code
	output logic            headroom_offset_select_o, // 1 = 300 mV
	output logic      [3:0] pump_switch_o  // four charge pump switches
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	status_in_s raw_w;
	status_in_s meta_reg;
	status_in_s sync_reg;

	assign raw_w = '{pos_en: pos_rail_enable_pin_i,
		neg_en: neg_rail_enable_pin_i,
		lockout_ok: supply_lockout_ok_i,
		over_temp: over_temp_i,
		boost_ready: boost_ready_i};

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else if (clk_en_i) begin
			meta_reg <= raw_w; // (R23)
			sync_reg <= meta_reg; // (R23)
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [4:0] pos_code_reg;
	logic [4:0] neg_code_reg;
	logic [7:0] control_reg;
	logic [7:0] rdata_reg;
	logic       any_pin_w;
	logic       port_open_w;
	logic       wr_ok_w;
	logic       rd_ok_w;
	logic [7:0] status_w;
	logic [7:0] rsel_w;

	assign any_pin_w   = sync_reg.pos_en | sync_reg.neg_en;
	// alternate variant: inputs dead while both pins low
	assign port_open_w = !GATED_SERIAL || any_pin_w; // (R19) (R20)
	assign wr_ok_w     = wr_i && port_open_w;
	assign rd_ok_w     = rd_i && port_open_w;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pos_code_reg <= CODE_RESET; // (R21)
			neg_code_reg <= CODE_RESET; // (R21)
			control_reg  <= CONTROL_RESET; // (R3)
		end else if (clk_en_i && wr_ok_w) begin
			// reserved control bits are stored as written; code bits 7:5 are dropped; software keeps them zero
			if (addr_i == POS_CODE_OFS)
				pos_code_reg <= wdata_i[4:0]; // (R11)
			if (addr_i == NEG_CODE_OFS)
				neg_code_reg <= wdata_i[4:0]; // (R14)
			if (addr_i == CONTROL_OFS)
				control_reg <= wdata_i; // (R3) (R17)
		end
	end

	// ----------------------------------------------------------------
	// rail state machines
	// ----------------------------------------------------------------
	rail_state_e pos_st_reg;
	rail_state_e neg_st_reg;
	rail_state_e pos_st_next;
	rail_state_e neg_st_next;
	logic        pos_en_prev_reg;
	logic        neg_en_prev_reg;
	logic        supply_good_w;
	logic        pos_want_w;
	logic        neg_want_w;
	logic        power_down_w;
	logic        pos_dis_sel_w;
	logic        neg_dis_sel_w;
	logic        boost_next;

	// thermal flag is held by the sensor until 15 degrees of cooling
	assign supply_good_w = sync_reg.lockout_ok && !sync_reg.over_temp; // (R1) (R16)
	assign pos_want_w = sync_reg.pos_en | control_reg[REG_EN_POS_BIT]; // (R18)
	assign neg_want_w = sync_reg.neg_en | control_reg[REG_EN_NEG_BIT]; // (R18)
	// power-down only once neither rail remains requested
	assign power_down_w = !pos_want_w && !neg_want_w; // (R4) (R5)
	assign pos_dis_sel_w = control_reg[DIS_POS_BIT];
	assign neg_dis_sel_w = control_reg[DIS_NEG_BIT];
	assign boost_next = supply_good_w && (pos_want_w || neg_want_w); // (R6) (R7) (R8)
	assign status_w = {3'h0, pos_st_reg == RAIL_ON, neg_st_reg == RAIL_ON,
		sync_reg.boost_ready, sync_reg.over_temp, sync_reg.lockout_ok};

	// every input is an argument so the continuous assignments below
	// re-evaluate whenever any of them changes
	function automatic rail_state_e rail_step(
		input rail_state_e cur,
		input logic        want,
		input logic        was_on,
		input logic        dis_sel,
		input logic        good,
		input logic        pdown,
		input logic        bready
	);
		rail_state_e nxt;
		nxt = cur;
		unique case (cur)
			RAIL_OFF: begin
				if (good && want && bready)
					nxt = RAIL_START; // (R2) (R9) (R12)
				else if (pdown && dis_sel && was_on)
					nxt = RAIL_DRAIN; // (R4)
			end
			RAIL_START: begin
				if (!good || !want)
					nxt = RAIL_OFF; // (R10) (R13)
				else
					nxt = RAIL_ON;
			end
			RAIL_ON: begin
				if (!good || !want)
					nxt = RAIL_OFF; // (R1) (R10) (R13)
			end
			RAIL_DRAIN: begin
				// leave before any restart or if selection dropped
				if (want || !pdown || !dis_sel)
					nxt = RAIL_OFF; // (R24)
			end
		endcase
		return nxt;
	endfunction

	assign pos_st_next = rail_step(pos_st_reg, pos_want_w,
		pos_en_prev_reg, pos_dis_sel_w, supply_good_w, power_down_w,
		sync_reg.boost_ready);
	assign neg_st_next = rail_step(neg_st_reg, neg_want_w,
		neg_en_prev_reg, neg_dis_sel_w, supply_good_w, power_down_w,
		sync_reg.boost_ready);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pos_st_reg      <= RAIL_OFF;
			neg_st_reg      <= RAIL_OFF;
			pos_en_prev_reg <= 1'b0;
			neg_en_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			pos_st_reg <= pos_st_next;
			neg_st_reg <= neg_st_next;
			// remembers a rail that has been up since it last passed through RAIL_DRAIN
			if (pos_st_reg == RAIL_ON)
				pos_en_prev_reg <= 1'b1;
			else if (pos_st_reg == RAIL_DRAIN || !power_down_w)
				pos_en_prev_reg <= pos_en_prev_reg && !(pos_st_reg == RAIL_DRAIN);
			if (neg_st_reg == RAIL_ON)
				neg_en_prev_reg <= 1'b1;
			else if (neg_st_reg == RAIL_DRAIN || !power_down_w)
				neg_en_prev_reg <= neg_en_prev_reg && !(neg_st_reg == RAIL_DRAIN);
		end
	end

	// ----------------------------------------------------------------
	// charge pump phase driver
	// ----------------------------------------------------------------
	logic [9:0] pump_cnt_reg;
	logic       pump_phase_reg;
	logic       pump_on_w;

	assign pump_on_w = (neg_st_next == RAIL_START) || (neg_st_next == RAIL_ON);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pump_cnt_reg   <= '0;
			pump_phase_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (!pump_on_w) begin
				pump_cnt_reg   <= '0;
				pump_phase_reg <= 1'b0;
			end else if (pump_cnt_reg == 10'(PUMP_HALF_CYC - 1)) begin
				pump_cnt_reg   <= '0;
				pump_phase_reg <= !pump_phase_reg; // (R15)
			end else begin
				pump_cnt_reg <= pump_cnt_reg + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	logic [3:0] sw_next;

	// phase 0 closes two switches, phase 1 inverts all four
	assign sw_next = !pump_on_w ? 4'h0 :
		(pump_phase_reg ? 4'hC : 4'h3); // (R15)

	assign rsel_w = (addr_i == POS_CODE_OFS) ? {3'h0, pos_code_reg} :
		(addr_i == NEG_CODE_OFS) ? {3'h0, neg_code_reg} :
		(addr_i == STATUS_OFS)   ? status_w : control_reg;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			rdata_reg                <= 8'h00;
			boost_run_o              <= 1'b0;
			linear_regulator_run_o   <= 1'b0;
			pump_run_o               <= 1'b0;
			pos_discharge_o          <= 1'b0;
			neg_discharge_o          <= 1'b0;
			pos_voltage_code_o       <= CODE_RESET;
			neg_voltage_code_o       <= CODE_RESET;
			headroom_offset_select_o <= 1'b0;
			pump_switch_o            <= 4'h0;
		end else if (clk_en_i) begin
			rdata_reg <= rd_ok_w ? rsel_w : 8'h00;
			boost_run_o <= boost_next; // (R6) (R8)
			linear_regulator_run_o <= (pos_st_next == RAIL_START) ||
				(pos_st_next == RAIL_ON); // (R9) (R10)
			pump_run_o <= pump_on_w; // (R12) (R13)
			pos_discharge_o <= pos_st_next == RAIL_DRAIN; // (R24)
			neg_discharge_o <= neg_st_next == RAIL_DRAIN; // (R24)
			pos_voltage_code_o <= pos_code_reg; // (R11)
			neg_voltage_code_o <= neg_code_reg; // (R14)
			headroom_offset_select_o <= control_reg[OFFSET_BIT]; // (R17)
			pump_switch_o <= sw_next;
		end
	end

	assign rdata_o = rdata_reg;

endmodule

// file: sim/bias_analog_model.sv
// Purpose: stand-in for the boost stage and its target comparator
// Assumes: boost output needs SETTLE cycles to reach target
// Notes:   ready drops at once when the boost stops, as a real rail sags
`timescale 1ns/1ps
module bias_analog_model #(
	parameter int SETTLE = 8 // cycles from boost start to target
) (
	input  wire logic clock_i,       // core clock
	input  wire logic boost_run_i,   // boost stage enable
	output logic      boost_ready_o  // boost at target
);
	int ramp = 0;
	always @(posedge clock_i) begin
		ramp <= boost_run_i ? ((ramp < SETTLE) ? ramp + 1 : ramp) : 0;
		boost_ready_o <= boost_run_i && (ramp >= SETTLE);
	end
	initial boost_ready_o = 1'b0;
endmodule

// file: sim/bias_seq_monitor.sv
// Purpose: port level checks of the bias sequencer
// Assumes: clk_en_i held high; synchroniser latency under six cycles
// Notes:   bound to the top module
`timescale 1ns/1ps
module bias_seq_monitor
	import bias_seq_pkg::*;
(
	input wire logic       clock_i,                // clock
	input wire logic       rst_b_i,                // reset
	input wire logic       pos_rail_enable_pin_i,  // pin
	input wire logic       neg_rail_enable_pin_i,  // pin
	input wire logic       supply_lockout_ok_i,    // supply good
	input wire logic       over_temp_i,            // too hot
	input wire logic       boost_run_o,            // boost
	input wire logic       linear_regulator_run_o, // regulator
	input wire logic       pump_run_o,             // pump
	input wire logic       pos_discharge_o,        // drain
	input wire logic       neg_discharge_o,        // drain
	input wire logic [4:0] pos_voltage_code_o,     // code
	input wire logic [4:0] neg_voltage_code_o,     // code
	input wire logic [3:0] pump_switch_o           // switches
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_lock;
		!supply_lockout_ok_i [*6] |-> !boost_run_o && !pump_run_o;
	endproperty
	a_lock: assert property (p_lock) else $error("stage on, supply low");
	property p_hot;
		over_temp_i [*6] |-> !boost_run_o && !linear_regulator_run_o;
	endproperty
	a_hot: assert property (p_hot) else $error("stage on while hot");
	property p_ldo_boost;
		$rose(linear_regulator_run_o) |-> boost_run_o;
	endproperty
	a_ldo_boost: assert property (p_ldo_boost) else $error("ldo early");
	property p_pump_boost;
		$rose(pump_run_o) |-> boost_run_o;
	endproperty
	a_pump_boost: assert property (p_pump_boost) else $error("pump early");
	property p_pdis;
		pos_discharge_o |-> !linear_regulator_run_o;
	endproperty
	a_pdis: assert property (p_pdis) else $error("pos drain while on");
	property p_ndis;
		neg_discharge_o |-> !pump_run_o;
	endproperty
	a_ndis: assert property (p_ndis) else $error("neg drain while on");
	property p_one_on;
		(pos_rail_enable_pin_i || neg_rail_enable_pin_i) [*6]
			|-> !pos_discharge_o && !neg_discharge_o;
	endproperty
	a_one_on: assert property (p_one_on) else $error("drain, rail on");
	property p_phase;
		pump_switch_o != 4'h0 |-> pump_switch_o inside {4'h3, 4'hC};
	endproperty
	a_phase: assert property (p_phase) else $error("bad pump phase");
	property p_codes;
		$rose(rst_b_i) |-> pos_voltage_code_o == CODE_RESET
			&& neg_voltage_code_o == CODE_RESET;
	endproperty
	a_codes: assert property (p_codes) else $error("bad reset code");
	c_ldo: cover property ($rose(linear_regulator_run_o));
	c_pump: cover property ($rose(pump_run_o));
	c_drain: cover property ($rose(neg_discharge_o));
endmodule
bind dual_rail_bias_sequencer bias_seq_monitor u_mon (
	.clock_i(clock_i), .rst_b_i(rst_b_i),
	.pos_rail_enable_pin_i(pos_rail_enable_pin_i),
	.neg_rail_enable_pin_i(neg_rail_enable_pin_i),
	.supply_lockout_ok_i(supply_lockout_ok_i), .over_temp_i(over_temp_i),
	.boost_run_o(boost_run_o), .pump_run_o(pump_run_o),
	.linear_regulator_run_o(linear_regulator_run_o),
	.pos_discharge_o(pos_discharge_o), .neg_discharge_o(neg_discharge_o),
	.pos_voltage_code_o(pos_voltage_code_o),
	.neg_voltage_code_o(neg_voltage_code_o), .pump_switch_o(pump_switch_o));

// file: sim/dual_rail_bias_sequencer_tb.sv
// Purpose: directed tests of the bias sequencer
// Assumes: base variant; clock enable held high
// Notes:   settle waits cover synchronisers plus boost ramp
`timescale 1ns/1ps
module dual_rail_bias_sequencer_tb;
	import bias_seq_pkg::*;
	logic clock_i = 0, rst_b_i = 0, pos_pin = 0, neg_pin = 0, lok = 1, hot = 0;
	logic wr = 0, rd = 0, ready, boost, linear_regulator, pump, pdis, ndis, hsel;
	logic [1:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic [4:0] pcode, ncode;
	logic [3:0] sw, s;
	int bad_count = 0, n_tests = 0, cyc = 0;
	wire [7:0] st = {3'h0, boost, linear_regulator, pump, pdis, ndis};
	dual_rail_bias_sequencer DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.clk_en_i(1'b1), .pos_rail_enable_pin_i(pos_pin),
		.neg_rail_enable_pin_i(neg_pin), .supply_lockout_ok_i(lok),
		.over_temp_i(hot), .boost_ready_i(ready), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.boost_run_o(boost), .linear_regulator_run_o(linear_regulator), .pump_run_o(pump),
		.pos_discharge_o(pdis), .neg_discharge_o(ndis),
		.pos_voltage_code_o(pcode), .neg_voltage_code_o(ncode),
		.headroom_offset_select_o(hsel), .pump_switch_o(sw));
	bias_analog_model u_model (.clock_i(clock_i), .boost_run_i(boost),
		.boost_ready_o(ready));
	initial forever #2.5 clock_i = ~clock_i;
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		chk(rdata, v);
	endtask
	task automatic pins(input logic p, input logic n);
		@(posedge clock_i);
		pos_pin <= p;
		neg_pin <= n;
		wt(30);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rreg(POS_CODE_OFS, 8'h0A);
		rreg(NEG_CODE_OFS, 8'h0A);
		rreg(CONTROL_OFS, 8'h03);
		wreg(STATUS_OFS, 8'hFF);
		rreg(STATUS_OFS, 8'h01);
		chk(st, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_rails;
		pins(1, 0);
		chk(st, 8'h18);
		pins(1, 1);
		chk(st, 8'h1C);
		pins(0, 1);
		chk(st, 8'h14);
		pins(0, 0);
		chk(st & 8'hFD, 8'h01);
		pins(1, 0);
		chk(st, 8'h18);
		pins(0, 0);
		$display("t_rails done");
	endtask
	task automatic t_pump;
		pins(0, 1);
		s = sw;
		chk({7'h0, s == 4'h3 || s == 4'hC}, 8'h01);
		wt(PUMP_HALF_CYC);
		chk({4'h0, sw}, {4'h0, ~s});
		wreg(CONTROL_OFS, 8'h00);
		pins(0, 0);
		chk(st, 8'h00);
		wreg(CONTROL_OFS, 8'h03);
		$display("t_pump done");
	endtask
	task automatic t_codes;
		wreg(POS_CODE_OFS, 8'h1F);
		wreg(NEG_CODE_OFS, 8'h00);
		wreg(CONTROL_OFS, 8'h43);
		rreg(POS_CODE_OFS, 8'h1F);
		chk({2'h0, hsel, pcode}, 8'h3F);
		chk({3'h0, ncode}, 8'h00);
		wreg(CONTROL_OFS, 8'h0B);
		wt(30);
		chk(st, 8'h18);
		wreg(CONTROL_OFS, 8'h03);
		wt(30);
		$display("t_codes done");
	endtask
	task automatic t_fault;
		@(posedge clock_i);
		lok <= 1'b0;
		pins(1, 1);
		chk(st & 8'h1C, 8'h00);
		@(posedge clock_i);
		lok <= 1'b1;
		wt(30);
		chk(st, 8'h1C);
		@(posedge clock_i);
		hot <= 1'b1;
		wt(10);
		chk(st & 8'h1C, 8'h00);
		@(posedge clock_i);
		hot <= 1'b0;
		wt(30);
		chk(st, 8'h1C);
		pins(0, 0);
		$display("t_fault done");
	endtask
	task automatic close_out;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_rails();
		t_pump();
		t_codes();
		t_fault();
		close_out();
	end
endmodule
